// File: core/mpt_pkg.sv
// Shared constants and types for the motor PWM and conversion trigger chain.
// Assumes a single 25 MHz system clock feeding every register of the block.
package mpt_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEAD_TIME_NS = 500;
  localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_W = 8;
  localparam logic [DEAD_W-1:0] DEAD_LOAD = DEAD_W'(DEAD_CYC);

  // ------------------------------------------------------------
  // PWM timer
  // ------------------------------------------------------------
  localparam int PWM_CNT_W = 16;
  localparam int PWM_INIT_DEF = -3600;
  localparam int PWM_FINAL_DEF = 3599;
  localparam int CH_TOTAL = 8;
  localparam int PAIRS = 3;
  localparam logic [CH_TOTAL-1:0] OUT_MASK_FIXED = 8'hc0;

  // ------------------------------------------------------------
  // Slow loop timer
  // ------------------------------------------------------------
  localparam int SLOW_DIV = 16;
  localparam int SLOW_PRE_W = 4;
  localparam logic [SLOW_PRE_W-1:0] SLOW_PRE_LAST = SLOW_PRE_W'(SLOW_DIV - 1);
  localparam int SLOW_CNT_W = 16;

  // ------------------------------------------------------------
  // Converter settings
  // ------------------------------------------------------------
  localparam int CONV_CHAIN = 3;
  localparam logic [3:0] CONV_RES_12BIT = 4'hc;
  localparam logic [3:0] CONV_DIV_NORMAL = 4'h1;
  localparam logic [3:0] CONV_DIV_CALIB = 4'h8;
  localparam logic [7:0] CONV_AVG_NONE = 8'h01;
  localparam logic [7:0] CONV_AVG_CALIB = 8'h20;
  localparam int DELAY_W = 16;

  typedef enum logic [1:0] {
    CV_NORMAL = 2'b01,
    CV_CALIB  = 2'b10
  } mpt_cv_type;

endpackage

// File: core/mpt_delay_chan.sv
// One trigger delay channel: counts ticks of the slow async clock after a start.
// Assumes tick_i is already synchronised and lasts one system clock cycle.
`timescale 1ns/1ns
module mpt_delay_chan
  import mpt_pkg::*;
#(
  parameter int W = DELAY_W
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [W-1:0] period_i,
  output logic busy_o,
  output logic fire_o
);

  logic busy_r, busy_nxt;
  logic fire_r, fire_nxt;
  logic [W-1:0] cnt_r, cnt_nxt;

  // ------------------------------------------------------------
  // Count to the period, then fire once
  // ------------------------------------------------------------
  always_comb begin
    busy_nxt = busy_r;
    cnt_nxt = cnt_r;
    fire_nxt = 1'b0;
    if (start_i) begin
      busy_nxt = 1'b1;
      cnt_nxt = '0;
    end else if (busy_r && tick_i) begin
      if (cnt_r + W'(1) >= period_i) begin
        fire_nxt = 1'b1;
        busy_nxt = 1'b0;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r <= 1'b0;
      fire_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      fire_r <= fire_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign busy_o = busy_r;
  assign fire_o = fire_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_fire_ends_busy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    fire_r |-> !busy_r) else $error("delay channel fired but still busy");

endmodule

// File: core/mpt_top.sv
// Motor timing block: PWM generator, trigger delay chain and slow loop timer.
// Assumes converters and a gate driver outside; async clock and done lines are pins.
//
// What this block does
// RL1: PWM counter advances on every system clock edge, no prescaler.
// RL2: Six PWM channels active; channels six and seven forced off by output mask.
// RL3: Channels pair as 0/1, 2/3, 4/5, each pair complementary.
// RL4: PWM counter runs from -3600 up to 3599; one span is one period.
// RL5: Default span at the system clock gives a 288 us, about 3.47 kHz period.
// RL6: Dead time counted in system clocks inserted on every pair edge, 0.5 us.
// RL7: Loading the counter initial value emits a trigger to the delay chain.
// RL8: Converters set for 12-bit single-ended conversions.
// RL9: Normal converter clock is the bus clock divided by one.
// RL10: Calibration slows converter clock to 3 MHz, continuous, averaging 32 samples.
// RL11: After calibration, converter settings return to defaults and full clock.
// RL12: Conversions start only from delay chain pre-triggers, never software.
// RL13: Delay channels count an async clock independent of the PWM clock.
// RL14: PWM trigger starts channel 0; its period end starts the first conversion.
// RL15: First conversion done starts channel 1; its end starts the second conversion.
// RL16: Second conversion done starts channel 2; its end starts the last conversion.
// RL17: Last conversion done raises the fast loop interrupt.
// RL18: Slow loop timer clocked by system clock divided by sixteen.
// RL19: Slow loop timer counts from zero to final value, interrupt at reload.
// RL20: Counters reload initial value after final value and keep counting.
`timescale 1ns/1ns
module mpt_top
  import mpt_pkg::*;
#(
  parameter int CNT_W = PWM_CNT_W,
  parameter int PWM_INIT = PWM_INIT_DEF,
  parameter int PWM_FINAL = PWM_FINAL_DEF
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [CNT_W-2:0] duty_a_i,
  input wire logic [CNT_W-2:0] duty_b_i,
  input wire logic [CNT_W-2:0] duty_c_i,
  input wire logic [5:0] output_mask_i,
  input wire logic [DELAY_W-1:0] delay_period0_i,
  input wire logic [DELAY_W-1:0] delay_period1_i,
  input wire logic [DELAY_W-1:0] delay_period2_i,
  input wire logic [SLOW_CNT_W-1:0] slow_final_i,
  input wire logic calib_req_i,
  input wire logic async_low_power_osc_i,
  input wire logic [CONV_CHAIN-1:0] conv_done_i,
  input wire logic calib_done_i,
  output logic [CH_TOTAL-1:0] pwm_o,
  output logic pwm_init_trigger_o,
  output logic [CONV_CHAIN-1:0] conv_start_o,
  output logic fast_irq_o,
  output logic slow_irq_o,
  output logic [3:0] conv_clk_div_o,
  output logic [3:0] conv_res_o,
  output logic conv_single_ended_o,
  output logic conv_continuous_o,
  output logic [7:0] conv_avg_o
);

  // RL5: Default span sets period
  localparam logic signed [CNT_W-1:0] INIT_V = CNT_W'(PWM_INIT);
  localparam logic signed [CNT_W-1:0] FINAL_V = CNT_W'(PWM_FINAL);

  initial begin
    if (PWM_INIT >= PWM_FINAL || PWM_INIT < -(2 ** (CNT_W - 1))
        || PWM_FINAL >= 2 ** (CNT_W - 1) || DEAD_CYC >= 2 ** DEAD_W) begin
      $error("mpt_top: counter span or dead time does not fit");
    end
  end

  function automatic logic in_window(input logic signed [CNT_W-1:0] c,
                                     input logic [CNT_W-2:0] duty);
    logic signed [CNT_W-1:0] d;
    d = signed'({1'b0, duty});
    in_window = (c >= -d) && (c < d);
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int SYN = CONV_CHAIN + 2;
  logic [SYN-1:0] syn1_r, syn2_r, syn3_r;
  logic osc_tick;
  logic [CONV_CHAIN-1:0] done_rise;
  logic calib_done_rise;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      syn1_r <= '0;
      syn2_r <= '0;
      syn3_r <= '0;
    end else begin
      syn1_r <= {calib_done_i, conv_done_i, async_low_power_osc_i};
      syn2_r <= syn1_r;
      syn3_r <= syn2_r;
    end
  end

  // RL13: Async clock edges
  assign osc_tick = syn2_r[0] & ~syn3_r[0];
  assign done_rise = syn2_r[CONV_CHAIN:1] & ~syn3_r[CONV_CHAIN:1];
  assign calib_done_rise = syn2_r[SYN-1] & ~syn3_r[SYN-1];

  // ------------------------------------------------------------
  // PWM counter and dead time
  // ------------------------------------------------------------
  logic signed [CNT_W-1:0] cnt_r, cnt_nxt;
  logic trig_r, trig_nxt;
  logic [PAIRS-1:0] ref_r, ref_nxt;
  logic [DEAD_W-1:0] dt_r [PAIRS];
  logic [DEAD_W-1:0] dt_nxt [PAIRS];
  logic [CH_TOTAL-1:0] pwm_r, pwm_nxt;
  logic [CH_TOTAL-1:0] mask_all;

  always_comb begin
    // RL1: Count every clock
    cnt_nxt = cnt_r + CNT_W'(1);
    trig_nxt = 1'b0;
    // RL4: Span from initial to final
    // RL20: Reload and continue
    if (cnt_r == FINAL_V) begin
      cnt_nxt = INIT_V;
      // RL7: Trigger on reload
      trig_nxt = 1'b1;
    end
    ref_nxt[0] = in_window(cnt_nxt, duty_a_i);
    ref_nxt[1] = in_window(cnt_nxt, duty_b_i);
    ref_nxt[2] = in_window(cnt_nxt, duty_c_i);
    // RL2: Fixed mask on spare channels
    mask_all = OUT_MASK_FIXED | {2'b00, output_mask_i};
    pwm_nxt = '0;
    for (int p = 0; p < PAIRS; p++) begin
      // RL6: Dead time on each edge
      if (ref_nxt[p] != ref_r[p]) begin
        dt_nxt[p] = DEAD_LOAD;
      end else if (dt_r[p] != '0) begin
        dt_nxt[p] = dt_r[p] - DEAD_W'(1);
      end else begin
        dt_nxt[p] = dt_r[p];
      end
      // RL3: Complementary pairs
      pwm_nxt[2*p] = ref_nxt[p] && (dt_nxt[p] == '0) && !mask_all[2*p];
      pwm_nxt[2*p+1] = !ref_nxt[p] && (dt_nxt[p] == '0) && !mask_all[2*p+1];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= INIT_V;
      trig_r <= 1'b0;
      ref_r <= '0;
      pwm_r <= '0;
      for (int p = 0; p < PAIRS; p++) begin
        dt_r[p] <= DEAD_LOAD;
      end
    end else begin
      cnt_r <= cnt_nxt;
      trig_r <= trig_nxt;
      ref_r <= ref_nxt;
      pwm_r <= pwm_nxt;
      for (int p = 0; p < PAIRS; p++) begin
        dt_r[p] <= dt_nxt[p];
      end
    end
  end

  // ------------------------------------------------------------
  // Trigger delay chain
  // ------------------------------------------------------------
  logic [CONV_CHAIN-1:0] ch_start, ch_fire, ch_busy;
  logic [DELAY_W-1:0] ch_period [CONV_CHAIN];
  logic [CONV_CHAIN-1:0] start_r, start_nxt;
  logic fast_r, fast_nxt;

  assign ch_period[0] = delay_period0_i;
  assign ch_period[1] = delay_period1_i;
  assign ch_period[2] = delay_period2_i;
  // RL14: PWM trigger starts channel 0
  // RL15: First done starts channel 1
  // RL16: Second done starts channel 2
  assign ch_start = {done_rise[1:0], trig_r};

  for (genvar g = 0; g < CONV_CHAIN; g++) begin : g_chan
    mpt_delay_chan #(.W(DELAY_W)) u_chan (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .start_i(ch_start[g]),
      .tick_i(osc_tick),
      .period_i(ch_period[g]),
      .busy_o(ch_busy[g]),
      .fire_o(ch_fire[g])
    );
  end

  always_comb begin
    // RL12: Only pre-triggers start conversions
    start_nxt = ch_fire;
    // RL17: Last done raises fast loop interrupt
    fast_nxt = done_rise[CONV_CHAIN-1];
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_r <= '0;
      fast_r <= 1'b0;
    end else begin
      start_r <= start_nxt;
      fast_r <= fast_nxt;
    end
  end

  // ------------------------------------------------------------
  // Converter settings and calibration
  // ------------------------------------------------------------
  mpt_cv_type cv_r, cv_nxt;
  logic [3:0] div_r, div_nxt;
  logic cont_r, cont_nxt;
  logic [7:0] avg_r, avg_nxt;
  logic [3:0] res_r, res_nxt;
  logic se_r, se_nxt;

  always_comb begin
    cv_nxt = cv_r;
    case (cv_r)
      CV_NORMAL: begin
        if (calib_req_i) begin
          cv_nxt = CV_CALIB;
        end
      end
      CV_CALIB: begin
        // RL11: Back to defaults when done
        if (calib_done_rise) begin
          cv_nxt = CV_NORMAL;
        end
      end
      default: cv_nxt = CV_NORMAL;
    endcase
    // RL8: 12-bit single-ended mode
    res_nxt = CONV_RES_12BIT;
    se_nxt = 1'b1;
    // RL9: Divide by one normally
    div_nxt = CONV_DIV_NORMAL;
    cont_nxt = 1'b0;
    avg_nxt = CONV_AVG_NONE;
    // RL10: Slow, continuous, averaged calibration
    if (cv_nxt == CV_CALIB) begin
      div_nxt = CONV_DIV_CALIB;
      cont_nxt = 1'b1;
      avg_nxt = CONV_AVG_CALIB;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cv_r <= CV_NORMAL;
      div_r <= CONV_DIV_NORMAL;
      cont_r <= 1'b0;
      avg_r <= CONV_AVG_NONE;
      res_r <= CONV_RES_12BIT;
      se_r <= 1'b1;
    end else begin
      cv_r <= cv_nxt;
      div_r <= div_nxt;
      cont_r <= cont_nxt;
      avg_r <= avg_nxt;
      res_r <= res_nxt;
      se_r <= se_nxt;
    end
  end

  // ------------------------------------------------------------
  // Slow loop timer
  // ------------------------------------------------------------
  logic [SLOW_PRE_W-1:0] pre_r, pre_nxt;
  logic [SLOW_CNT_W-1:0] slow_r, slow_nxt;
  logic slow_irq_r, slow_irq_nxt;

  always_comb begin
    // RL18: Divide by sixteen
    pre_nxt = pre_r + SLOW_PRE_W'(1);
    slow_nxt = slow_r;
    slow_irq_nxt = 1'b0;
    if (pre_r == SLOW_PRE_LAST) begin
      // RL19: Interrupt on reload
      if (slow_r >= slow_final_i) begin
        slow_nxt = '0;
        slow_irq_nxt = 1'b1;
      end else begin
        slow_nxt = slow_r + SLOW_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_r <= '0;
      slow_r <= '0;
      slow_irq_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      slow_r <= slow_nxt;
      slow_irq_r <= slow_irq_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign pwm_o = pwm_r;
  assign pwm_init_trigger_o = trig_r;
  assign conv_start_o = start_r;
  assign fast_irq_o = fast_r;
  assign slow_irq_o = slow_irq_r;
  assign conv_clk_div_o = div_r;
  assign conv_res_o = res_r;
  assign conv_single_ended_o = se_r;
  assign conv_continuous_o = cont_r;
  assign conv_avg_o = avg_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_wrap;
    cnt_r == FINAL_V;
  endsequence
  sequence s_trig_load;
    trig_r && cnt_r == INIT_V;
  endsequence

  chk_pwm_step: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL1
    cnt_r != FINAL_V |=> cnt_r == $past(cnt_r) + CNT_W'(1)) else $error("counter skipped");
  chk_span_wrap: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL4
    s_wrap |=> s_trig_load) else $error("counter did not reload with trigger");
  chk_trig_cause: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL7
    trig_r |-> $past(cnt_r) == FINAL_V) else $error("trigger without reload");
  chk_spare_off: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL2
    pwm_o[7:6] == 2'b00) else $error("spare channel active");
  chk_pair_excl: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL3
    !(pwm_o[0] && pwm_o[1]) && !(pwm_o[2] && pwm_o[3]) && !(pwm_o[4] && pwm_o[5]))
    else $error("pair shoot-through");
  chk_dead_gap: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL6
    $fell(pwm_o[0]) |=> !pwm_o[1] [*8]) else $error("dead time too short");
  chk_chain_start: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL14
    trig_r |=> ch_busy[0]) else $error("channel 0 not started");
  chk_conv_pretrig: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL12
    conv_start_o != '0 |-> $past(ch_fire) == conv_start_o) else $error("unsolicited start");
  chk_fast_irq: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL17
    done_rise[2] |=> fast_irq_o) else $error("fast interrupt missing");
  chk_calib_cfg: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL10
    cv_r == CV_CALIB |-> div_r == CONV_DIV_CALIB && cont_r && avg_r == CONV_AVG_CALIB)
    else $error("calibration settings wrong");
  chk_calib_exit: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL11
    cv_r == CV_CALIB && calib_done_rise |=> div_r == CONV_DIV_NORMAL && !cont_r)
    else $error("settings not restored");
  chk_slow_div: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL18
    slow_irq_o |=> !slow_irq_o [*8]) else $error("slow interrupt too frequent");
  chk_slow_reload: assert property (@(posedge clk_i) disable iff (!arst_n_i) // RL19
    slow_irq_o |-> slow_r == '0) else $error("slow interrupt without reload");

endmodule

// File: bench/mpt_partner.sv
// Converter and gate driver model facing the motor timing block.
// Assumes one system clock; done and calibration lines are plain levels.
`timescale 1ns/1ns
module mpt_partner #(
  parameter int DONE_DLY = 2,
  parameter int CAL_DLY = 30
) (
  input wire logic clk_i,
  input wire logic [2:0] conv_start_i,
  input wire logic conv_continuous_i,
  input wire logic [7:0] pwm_i,
  output logic [2:0] conv_done_o,
  output logic calib_done_o,
  output int shoot_o
);
  int busy [3];
  int cal_cnt;
  logic cont_q;

  initial begin
    busy = '{default: 0};
    cal_cnt = 0;
    cont_q = 1'b0;
    conv_done_o = 3'h0;
    calib_done_o = 1'b0;
    shoot_o = 0;
  end

  always @(posedge clk_i) begin
    for (int n = 0; n < 3; n++) begin
      if (conv_start_i[n]) busy[n] <= DONE_DLY + 2;
      else if (busy[n] > 0) busy[n] <= busy[n] - 1;
      conv_done_o[n] <= (busy[n] == 1) || (busy[n] == 2);
    end
    cont_q <= conv_continuous_i;
    if (conv_continuous_i && !cont_q) cal_cnt <= CAL_DLY;
    else if (cal_cnt > 0) cal_cnt <= cal_cnt - 1;
    calib_done_o <= (cal_cnt > 0) && (cal_cnt <= 3);
    if ((pwm_i[0] & pwm_i[1]) | (pwm_i[2] & pwm_i[3]) | (pwm_i[4] & pwm_i[5]))
      shoot_o <= shoot_o + 1;
  end
endmodule

// File: bench/motor_pwm_adc_trigger_chain_test.sv
// Self-checking bench for the motor timing block with converter model.
// Assumes mpt_top with a shortened PWM span; done lines come from the partner model, all other inputs driven from here.
`timescale 1ns/1ns
module motor_pwm_adc_trigger_chain_test import mpt_pkg::*; ;
  localparam int SPAN = 200;
  localparam int NIT = 6;
  localparam logic [31:0] CAL_NORM = {14'h0000, CONV_RES_12BIT, 1'b1, CONV_DIV_NORMAL,
                                      1'b0, CONV_AVG_NONE};
  localparam logic [31:0] CAL_CAL = {14'h0000, CONV_RES_12BIT, 1'b1, CONV_DIV_CALIB,
                                     1'b1, CONV_AVG_CALIB};
  logic clk = 1'b0;
  logic arst_n, calib_req, osc, calib_done, osc_go, trig, fast_irq, slow_irq, cont, se;
  logic [14:0] duty [3];
  logic [15:0] per [3];
  logic [15:0] slow_final;
  logic [5:0] mask;
  logic [2:0] conv_done, conv_start;
  logic [7:0] pwm, avg;
  logic [3:0] div, res;
  int shoot, seed, n_mismatch, n_checks, osc_cnt;
  logic [31:0] q_pwm [$], q_chain [$], q_slow [$], q_cal [$];

  // ------------------------------------------------------------
  // Design and partner
  // ------------------------------------------------------------
  mpt_top #(.PWM_INIT(-100), .PWM_FINAL(99)) uut (
    .clk_i(clk), .arst_n_i(arst_n), .duty_a_i(duty[0]), .duty_b_i(duty[1]),
    .duty_c_i(duty[2]), .output_mask_i(mask), .delay_period0_i(per[0]),
    .delay_period1_i(per[1]), .delay_period2_i(per[2]), .slow_final_i(slow_final),
    .calib_req_i(calib_req), .async_low_power_osc_i(osc), .conv_done_i(conv_done),
    .calib_done_i(calib_done), .pwm_o(pwm), .pwm_init_trigger_o(trig),
    .conv_start_o(conv_start), .fast_irq_o(fast_irq), .slow_irq_o(slow_irq),
    .conv_clk_div_o(div), .conv_res_o(res), .conv_single_ended_o(se),
    .conv_continuous_o(cont), .conv_avg_o(avg));
  mpt_partner model (
    .clk_i(clk), .conv_start_i(conv_start), .conv_continuous_i(cont), .pwm_i(pwm),
    .conv_done_o(conv_done), .calib_done_o(calib_done), .shoot_o(shoot));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    if (trig === 1'b1) osc_go <= 1'b1;
    if (osc_go) begin
      osc_cnt <= (osc_cnt == 9) ? 0 : osc_cnt + 1;
      if (osc_cnt == 9) osc <= ~osc;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_hi(input int which);
    int k;
    for (k = 0; k < 1000; k++) begin
      @(posedge clk);
      if (which == 0 && trig === 1'b1) break;
      if (which == 1 && fast_irq === 1'b1) break;
    end
    if (k == 1000) begin
      n_mismatch++;
      $display("ERROR %0t wait ran out", $time);
    end
  endtask

  task automatic push_chain(input int p [3]);
    for (int n = 0; n < 3; n++) q_chain.push_back(32'((p[n] == 0) ? 1 : p[n]));
    q_chain.push_back(32'h0000_0003);
  endtask

  task automatic push_pwm(input int d [3], input logic [5:0] m);
    q_pwm.push_back(32'(SPAN));
    for (int k = 0; k < 3; k++) begin
      q_pwm.push_back(m[2*k] ? 32'h0000_0000 : 32'(2 * d[k] - DEAD_CYC));
      q_pwm.push_back(m[2*k+1] ? 32'h0000_0000 : 32'(SPAN - 2 * d[k] - DEAD_CYC));
    end
    q_pwm.push_back(32'h0000_0000);
    q_pwm.push_back(32'h0000_0000);
  endtask

  // ------------------------------------------------------------
  // Output monitor
  // ------------------------------------------------------------
  int per_len, tk, done_age, slow_age;
  int hi_n [8];
  logic osc_q, slow_seen;
  logic [2:0] done_q;
  logic [31:0] cal_now, cal_q;
  initial begin
    per_len = 0; tk = 0; done_age = 0; slow_age = 0; hi_n = '{default: 0};
    osc_q = 1'b0; slow_seen = 1'b0; done_q = 3'h0;
  end
  always @(negedge clk) begin
    if (arst_n === 1'b1) begin
      per_len++;
      for (int c = 0; c < 8; c++) if (pwm[c] === 1'b1) hi_n[c]++;
      if (osc && !osc_q) tk++;
      osc_q = osc;
      if (trig === 1'b1) begin
        if (q_pwm.size() >= 9) begin
          check(32'(per_len), q_pwm.pop_front());
          for (int c = 0; c < 8; c++) check(32'(hi_n[c]), q_pwm.pop_front());
        end
        per_len = 0;
        hi_n = '{default: 0};
        tk = 0;
      end
      done_age++;
      for (int n = 0; n < 3; n++) begin
        if (conv_done[n] && !done_q[n]) begin
          tk = 0;
          done_age = 0;
        end
        if (conv_start[n] === 1'b1 && q_chain.size() > 0)
          check(32'(tk), q_chain.pop_front());
      end
      done_q = conv_done;
      if (fast_irq === 1'b1 && q_chain.size() > 0)
        check(32'(done_age), q_chain.pop_front());
      slow_age++;
      if (slow_irq === 1'b1) begin
        if (slow_seen && q_slow.size() > 0) check(32'(slow_age), q_slow.pop_front());
        slow_seen = 1'b1;
        slow_age = 0;
      end
      cal_now = {14'h0000, res, se, div, cont, avg};
      if (cal_now !== cal_q && q_cal.size() > 0) check(cal_now, q_cal.pop_front());
      cal_q = cal_now;
    end
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    int p [3];
    int d [3];
    int sf;
    logic [5:0] m;
    seed = 52165;
    n_mismatch = 0; n_checks = 0; osc_cnt = 0;
    arst_n = 1'b0; calib_req = 1'b0; osc = 1'b0; osc_go = 1'b0;
    duty = '{default: 15'h000a}; per = '{default: 16'h0001};
    mask = 6'h00; slow_final = 16'h0000;
    q_cal.push_back(CAL_NORM);
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    sf = $unsigned($random(seed)) % 8;
    slow_final <= 16'(sf);
    for (int k = 0; k < 10; k++) q_slow.push_back(32'(16 * (sf + 1)));
    for (int it = 0; it < NIT; it++) begin
      wait_hi(1);
      for (int n = 0; n < 3; n++) begin
        p[n] = $unsigned($random(seed)) % 3;
        d[n] = 7 + $unsigned($random(seed)) % 54;
        per[n] <= 16'(p[n]);
        duty[n] <= 15'(d[n]);
      end
      m = 6'($random(seed));
      mask <= m;
      push_chain(p);
      if (it == 2 || it == 4) begin
        calib_req <= 1'b1;
        q_cal.push_back(CAL_CAL);
        q_cal.push_back(CAL_NORM);
        @(posedge clk);
        calib_req <= 1'b0;
      end
      wait_hi(0);
      push_pwm(d, m);
      push_chain(p);
      wait_hi(0);
    end
    wait_hi(1);
    repeat (5) @(posedge clk);
    check(32'(shoot), 32'h0000_0000);
    check(32'(q_pwm.size() + q_chain.size() + q_cal.size() + q_slow.size()),
          32'h0000_0000);
    conclude();
  end

  initial begin
    #400000;
    n_mismatch++;
    $display("ERROR %0t run took too long", $time);
    conclude();
  end
endmodule
